// ### src/ccm_pkg.sv
// constants for the can control, length code and priority block
// assumes an apb master on pclk with 32-bit data
`default_nettype none
package ccm_pkg;
    // register byte offsets
    localparam logic [7:0] CTL_OFS   = 8'h00;
    localparam logic [7:0] INIT_OFS  = 8'h04;
    localparam logic [7:0] STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_OFS   = 8'h0C;
    localparam logic [7:0] MASK_OFS  = 8'h10;
    localparam logic [7:0] LEN_OFS   = 8'h14;
    localparam logic [7:0] TXE_OFS   = 8'h18;
    localparam logic [7:0] PRIO_OFS  = 8'h20;
    localparam logic [7:0] FRAME_OFS = 8'h30;
    // control field positions
    localparam int MODULE_ON_BIT  = 7;
    localparam int CLK_SRC_BIT    = 6;
    localparam int SELF_LOOP_BIT  = 5;
    localparam int LISTEN_BIT     = 4;
    localparam int BUSOFF_SEL_BIT = 3;
    localparam int WAKE_FILT_BIT  = 2;
    // init register bits
    localparam int INIT_REQ_BIT   = 0;
    localparam int WAKE_ALLOW_BIT = 1;
    localparam int RECOVER_BIT    = 2;
    // irq bits
    localparam int IRQ_TX   = 0;
    localparam int IRQ_RX   = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_BOFF = 3;
    localparam int IRQ_W    = 4;
    // reset value, data byte cap and dominant bus code
    localparam logic [7:0] CTL_RST  = 8'h00;
    localparam logic [3:0] LEN_MAX  = 4'h8;
    localparam logic [1:0] BUS_DOMINANT  = 2'h0;
    // wake filter minimum pulse
    localparam int WAKE_PULSE_MIN_NS = 2000;
    localparam int CLK_PERIOD_NS     = 4;
    localparam int WAKE_PULSE_CYC    =
        (WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_SEND} ccm_tx_e;
endpackage
`default_nettype wire

// ### src/ccm_ctrl.sv
// control register, length code handling and transmit buffer priority
// assumes a bit engine outside that runs frames and reports ack/errors
`default_nettype none
module ccm_ctrl
    import ccm_pkg::*;
#(
    parameter int NBUF          = 3,
    parameter int WAKE_CYC      = WAKE_PULSE_CYC,
    parameter int ERR_W         = 8
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // system
    input  wire logic        special_mode,
    output logic             irq,
    // bus pins
    input  wire logic        bus_receive_pin,
    output logic             bus_transmit_pin,
    // protocol engine side
    input  wire logic        eng_tx_bit,
    input  wire logic        eng_tx_busy,
    input  wire logic        eng_ack_slot,
    input  wire logic        eng_ack_bit,
    input  wire logic        eng_err_drive,
    input  wire logic        eng_tx_done,
    input  wire logic        eng_rx_done,
    input  wire logic        eng_rx_err,
    input  wire logic        eng_tx_err,
    input  wire logic        eng_busoff,
    input  wire logic        eng_busoff_done,
    input  wire logic        eng_init_ack,
    input  wire logic        eng_sof_next,
    input  wire logic        eng_remote,
    output logic             eng_rx_bit,
    output logic             eng_ack_ok,
    output logic             eng_start,
    output logic [1:0]       eng_buf_sel,
    output logic [3:0]       eng_data_bytes,
    output logic [3:0]       eng_len_code,
    output logic             eng_busoff_clear,
    output logic             clk_sel_bus,
    output logic             module_on,
    output logic             sleep_wake
);

    ////////////////////////////////////////////////////////////////
    logic [7:0]       ctl_r;
    logic             init_request_r;
    logic             wake_allow_r;
    logic             on_written_r;
    logic [IRQ_W-1:0] irq_r;
    logic [IRQ_W-1:0] mask_r;
    logic [NBUF-1:0]  tx_buffer_empty_flag_r;
    logic [7:0]       tx_buffer_local_priority_r [NBUF];
    logic [7:0]       frame_length_code_r [NBUF];
    logic [ERR_W-1:0] tx_err_cnt_r;
    logic [ERR_W-1:0] rx_err_cnt_r;
    logic             rx_s1_r;
    logic             rx_s2_r;
    logic             init_ack_r;
    logic [15:0]      wake_cnt_r;
    ccm_tx_e          tx_st_r;
    logic [1:0]       sel_r;

    logic wr;
    logic rd;
    logic init_mode;
    logic self_loop_test;
    logic listen_only;
    logic [IRQ_W-1:0] ev;

    assign wr             = psel && penable && pwrite;
    assign rd             = psel && penable && !pwrite;
    assign pready         = 1'b1;
    assign init_mode      = init_request_r && init_ack_r;
    assign self_loop_test = ctl_r[SELF_LOOP_BIT];
    assign listen_only    = ctl_r[LISTEN_BIT];
    assign module_on      = ctl_r[MODULE_ON_BIT];
    assign clk_sel_bus    = ctl_r[CLK_SRC_BIT];

    ////////////////////////////////////////////////////////////////
    // receive pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= bus_receive_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_ack_r <= 1'b0;
        end else begin
            init_ack_r <= eng_init_ack;
        end
    end

    ////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r        <= CTL_RST;
            on_written_r <= 1'b0;
        end else if (wr && paddr == CTL_OFS && init_mode) begin
            ctl_r[6:0] <= pwdata[6:0];
            if (special_mode || !on_written_r) begin
                ctl_r[MODULE_ON_BIT] <= pwdata[MODULE_ON_BIT];
                on_written_r         <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_request_r <= 1'b1;
            wake_allow_r   <= 1'b0;
        end else if (wr && paddr == INIT_OFS) begin
            init_request_r <= pwdata[INIT_REQ_BIT];
            wake_allow_r   <= pwdata[WAKE_ALLOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // buffers: empty flags, priorities, length codes
    genvar g;
    generate
        for (g = 0; g < NBUF; g++) begin : g_buf
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tx_buffer_empty_flag_r[g]     <= 1'b1;
                    tx_buffer_local_priority_r[g] <= 8'h00;
                    frame_length_code_r[g]        <= 8'h00;
                end else begin
                    // sent frame empties its buffer; done beats write
                    if (eng_tx_done && sel_r == 2'(g)) begin
                        tx_buffer_empty_flag_r[g] <= 1'b1;
                    end else if (wr && paddr == TXE_OFS
                                 && pwdata[g]) begin
                        tx_buffer_empty_flag_r[g] <= 1'b0;
                    end
                    if (wr && paddr == PRIO_OFS + 8'(4 * g)) begin
                        tx_buffer_local_priority_r[g] <= pwdata[7:0];
                    end
                    if (wr && paddr == FRAME_OFS + 8'(4 * g)) begin
                        frame_length_code_r[g] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // priority selection, evaluated just before start of frame
    logic [1:0] best;
    logic       any_full;
    always_comb begin
        best     = 2'd0;
        any_full = 1'b0;
        for (int i = 0; i < NBUF; i++) begin
            if (!tx_buffer_empty_flag_r[i]) begin
                if (!any_full || tx_buffer_local_priority_r[i]
                        < tx_buffer_local_priority_r[best]) begin
                    best = 2'(i);
                end
                any_full = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r <= ST_IDLE;
            sel_r   <= 2'd0;
        end else begin
            case (tx_st_r)
                ST_IDLE: begin
                    if (any_full && module_on && !init_request_r
                            && !listen_only) begin
                        tx_st_r <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    if (eng_sof_next) begin
                        sel_r   <= best;
                        tx_st_r <= (any_full && !listen_only)
                                   ? ST_SEND : ST_IDLE;
                    end
                end
                ST_SEND: begin
                    if (eng_tx_done || eng_tx_err) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    logic [3:0] code;
    assign code = frame_length_code_r[sel_r][3:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_start      <= 1'b0;
            eng_buf_sel    <= 2'd0;
            eng_len_code   <= 4'h0;
            eng_data_bytes <= 4'h0;
        end else begin
            eng_start      <= (tx_st_r == ST_ARB) && eng_sof_next
                              && any_full && !listen_only;
            eng_buf_sel    <= sel_r;
            eng_len_code   <= code;
            if (eng_remote) begin
                eng_data_bytes <= 4'h0;
            end else if (code > LEN_MAX) begin
                eng_data_bytes <= LEN_MAX;
            end else begin
                eng_data_bytes <= code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_transmit_pin <= 1'b1;
            eng_rx_bit       <= 1'b1;
            eng_ack_ok       <= 1'b0;
        end else begin
            if (self_loop_test) begin
                bus_transmit_pin <= 1'b1;
                eng_rx_bit       <= eng_tx_bit;
                eng_ack_ok       <= eng_ack_slot;
            end else begin
                // listen-only never drives ack or error frames
                bus_transmit_pin <= listen_only ? 1'b1 :
                    (eng_tx_busy || eng_err_drive ? eng_tx_bit : 1'b1);
                eng_rx_bit       <= rx_s2_r;
                eng_ack_ok       <= eng_ack_slot && !eng_ack_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // error counters, frozen in listen-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_err_cnt_r <= '0;
            rx_err_cnt_r <= '0;
        end else if (!listen_only) begin
            if (eng_tx_err && tx_err_cnt_r != '1) begin
                tx_err_cnt_r <= tx_err_cnt_r + 1'b1;
            end else if (eng_tx_done && tx_err_cnt_r != '0) begin
                tx_err_cnt_r <= tx_err_cnt_r - 1'b1;
            end
            if (eng_rx_err && rx_err_cnt_r != '1) begin
                rx_err_cnt_r <= rx_err_cnt_r + 1'b1;
            end else if (eng_rx_done && rx_err_cnt_r != '0) begin
                rx_err_cnt_r <= rx_err_cnt_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus-off recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_busoff_clear <= 1'b0;
        end else begin
            eng_busoff_clear <= eng_busoff && (ctl_r[BUSOFF_SEL_BIT]
                ? (wr && paddr == INIT_OFS && pwdata[RECOVER_BIT])
                : eng_busoff_done);
        end
    end

    ////////////////////////////////////////////////////////////////
    // wake-up detection on the synchronised receive level
    logic wake_hit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_r <= 16'h0000;
        end else if (rx_s2_r || !wake_allow_r) begin
            wake_cnt_r <= 16'h0000;
        end else if (wake_cnt_r != 16'hFFFF) begin
            wake_cnt_r <= wake_cnt_r + 16'h0001;
        end
    end
    // filtered mode waits out short glitches from the bus
    assign wake_hit = wake_allow_r && !rx_s2_r && (ctl_r[WAKE_FILT_BIT]
        ? (wake_cnt_r == 16'(WAKE_CYC - 1))
        : (wake_cnt_r == 16'h0000));
    assign sleep_wake = wake_hit;

    ////////////////////////////////////////////////////////////////
    // interrupts: set beats write-one-to-clear
    assign ev = {eng_busoff, wake_hit, eng_rx_done, eng_tx_done};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r  <= '0;
            mask_r <= '0;
        end else begin
            if (wr && paddr == IRQ_OFS) begin
                irq_r <= (irq_r & ~pwdata[IRQ_W-1:0]) | ev;
            end else begin
                irq_r <= irq_r | ev;
            end
            if (wr && paddr == MASK_OFS) begin
                mask_r <= pwdata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_r & mask_r);

    ////////////////////////////////////////////////////////////////
    // read mux and unmapped-address error
    logic        hit;
    logic [31:0] rdat;
    always_comb begin
        hit  = 1'b1;
        rdat = 32'h0000_0000;
        case (paddr)
            CTL_OFS:  rdat = {24'h00_0000, ctl_r};
            INIT_OFS: rdat = {29'h0, 1'b0, wake_allow_r, init_request_r};
            STAT_OFS: rdat = {8'h00, rx_err_cnt_r, tx_err_cnt_r,
                              6'h00, eng_busoff, init_ack_r};
            IRQ_OFS:  rdat = {28'h000_0000, irq_r};
            MASK_OFS: rdat = {28'h000_0000, mask_r};
            LEN_OFS:  rdat = {28'h000_0000, eng_data_bytes};
            TXE_OFS:  rdat = {{(32-NBUF){1'b0}}, tx_buffer_empty_flag_r};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NBUF; i++) begin
                    if (paddr == PRIO_OFS + 8'(4 * i)) begin
                        hit  = 1'b1;
                        rdat = {24'h00_0000,
                                tx_buffer_local_priority_r[i]};
                    end
                    if (paddr == FRAME_OFS + 8'(4 * i)) begin
                        hit  = 1'b1;
                        rdat = {24'h00_0000, frame_length_code_r[i]};
                    end
                end
            end
        endcase
    end
    assign pslverr = psel && penable && !hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdat;
        end
    end

endmodule
`default_nettype wire

// ### verification/ccm_ctrl_asserts.sv
// checker for ccm_ctrl: mode, pin and length properties at the ports
// assumes it is bound onto ccm_ctrl and sees only its ports
`default_nettype none
module ccm_ctrl_asserts
    import ccm_pkg::*;
(
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // pins and engine
    input wire logic        bus_transmit_pin,
    input wire logic        eng_tx_bit,
    input wire logic        eng_tx_busy,
    input wire logic        eng_ack_slot,
    input wire logic        eng_remote,
    input wire logic        eng_init_ack,
    input wire logic        eng_rx_bit,
    input wire logic        eng_ack_ok,
    input wire logic        eng_start,
    input wire logic [3:0]  eng_data_bytes,
    input wire logic        clk_sel_bus,
    input wire logic        module_on
);
    logic init_q, ack_q, loop_q, lis_q;
    wire logic wr_ctl = psel && penable && pwrite && paddr == CTL_OFS;
    wire logic wr_ini = psel && penable && pwrite && paddr == INIT_OFS;
    wire logic open_q = init_q && ack_q;

    ////////////////////////////////////////////////////////////////////
    // shadow of the mode bits, so the checks need no internal probes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_q <= 1'b1;
            ack_q  <= 1'b0;
            loop_q <= 1'b0;
            lis_q  <= 1'b0;
        end else begin
            ack_q <= eng_init_ack;
            if (wr_ini)
                init_q <= pwdata[INIT_REQ_BIT];
            if (wr_ctl && open_q) begin
                loop_q <= pwdata[SELF_LOOP_BIT];
                lis_q  <= pwdata[LISTEN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    clk_src_a: assert property ($changed(clk_sel_bus) |->
        $past(wr_ctl && open_q) && clk_sel_bus == $past(pwdata[6]))
        else $error("clock select changed without a legal write");
    mod_on_a: assert property ($changed(module_on) |->
        $past(wr_ctl && open_q) && module_on == $past(pwdata[7]))
        else $error("module enable changed without a legal write");
    loop_pin_a: assert property (loop_q && $past(loop_q)
        |-> bus_transmit_pin) else $error("pin driven in loopback");
    loop_route_a: assert property (loop_q && $past(loop_q) |->
        eng_rx_bit == $past(eng_tx_bit))
        else $error("receiver not fed from transmitter");
    loop_ack_a: assert property (loop_q && eng_ack_slot
        |=> eng_ack_ok) else $error("own frame not acknowledged");
    listen_pin_a: assert property (lis_q && $past(lis_q)
        |-> bus_transmit_pin) else $error("pin driven in listen mode");
    listen_start_a: assert property (lis_q |-> !eng_start)
        else $error("transmission started in listen mode");
    len_cap_a: assert property (eng_data_bytes <= LEN_MAX)
        else $error("data byte count above eight");
    remote_zero_a: assert property (eng_tx_busy && eng_remote &&
        $past(eng_remote) |-> eng_data_bytes == 4'h0)
        else $error("remote frame carries data bytes");
    slv_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");

    loop_c: cover property (loop_q && eng_start);
    listen_c: cover property (lis_q && eng_tx_bit == 1'b0);
    remote_c: cover property (eng_remote && eng_start);
endmodule

bind ccm_ctrl ccm_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pslverr, .bus_transmit_pin, .eng_tx_bit,
    .eng_tx_busy, .eng_ack_slot, .eng_remote, .eng_init_ack, .eng_rx_bit,
    .eng_ack_ok, .eng_start, .eng_data_bytes, .clk_sel_bus, .module_on);
`default_nettype wire

// ### verification/ccm_bus_node.sv
// remote node on the bus: recessive unless the bench pulls dominant
// assumes a wired-and bus whose pull-up gives recessive one
`default_nettype none
module ccm_bus_node (
    // bus
    input  wire logic tx_pin,
    output logic      rx_pin,
    // bench control
    input  wire logic dom_req
);
    timeunit 1ns;
    timeprecision 1ps;
    assign rx_pin = tx_pin & ~dom_req;
endmodule
`default_nettype wire

// ### verification/ccm_ctrl_tb_top.sv
// bench for ccm_ctrl: apb register tests, buffer selection and modes
// assumes the design, checker and bus node files are compiled first
`default_nettype none
module ccm_ctrl_tb_top
    import ccm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        special_mode, irq, rx_pin, tx_pin, dom, slv;
    logic        eng_tx_bit, eng_tx_busy, eng_ack_slot, eng_ack_bit;
    logic        eng_err_drive, eng_tx_done, eng_rx_done, eng_rx_err;
    logic        eng_tx_err, eng_init_ack, eng_sof_next, eng_remote;
    logic        eng_rx_bit, eng_ack_ok, eng_start, eng_busoff_clear;
    logic        clk_sel_bus, module_on, sleep_wake;
    logic        eng_busoff, eng_busoff_done;
    logic [1:0]  eng_buf_sel;
    logic [3:0]  eng_data_bytes, eng_len_code;
    int          mismatches, n_tests, cyc, i;
    logic [3:0]  prio[3] = '{4'h5, 4'h2, 4'h2};
    logic [3:0]  code[3] = '{4'h3, 4'hB, 4'h7};
    // expected order: lowest value wins, ties to the lower index
    logic [1:0]  e_sel[3] = '{2'h1, 2'h2, 2'h0};
    logic [3:0]  e_cnt[3] = '{4'h8, 4'h0, 4'h3};

    ccm_ctrl #(.NBUF(3), .WAKE_CYC(4)) i_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .special_mode, .irq, .bus_receive_pin(rx_pin),
        .bus_transmit_pin(tx_pin), .eng_tx_bit, .eng_tx_busy,
        .eng_ack_slot, .eng_ack_bit, .eng_err_drive, .eng_tx_done,
        .eng_rx_done, .eng_rx_err, .eng_tx_err, .eng_busoff,
        .eng_busoff_done, .eng_init_ack, .eng_sof_next, .eng_remote,
        .eng_rx_bit, .eng_ack_ok, .eng_start, .eng_buf_sel,
        .eng_data_bytes, .eng_len_code, .eng_busoff_clear, .clk_sel_bus,
        .module_on, .sleep_wake);
    ccm_bus_node u_node (.tx_pin, .rx_pin, .dom_req(dom));

    ////////////////////////////////////////////////////////////////////
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // request held from setup until pready is seen high at an edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic wait_start();
        int k;
        @(posedge pclk);
        eng_sof_next <= 1'b1;
        @(posedge pclk);
        eng_sof_next <= 1'b0;
        for (k = 0; k < 8 && eng_start !== 1'b1; k++) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, special_mode, dom} = '0;
        {eng_tx_bit, eng_tx_busy, eng_ack_slot, eng_ack_bit} = '0;
        {eng_err_drive, eng_tx_done, eng_rx_done, eng_rx_err} = '0;
        {eng_tx_err, eng_init_ack, eng_sof_next, eng_remote} = '0;
        {eng_busoff, eng_busoff_done} = '0;
        {paddr, pwdata, mismatches, n_tests, cyc} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(tx_pin, 1'b1);
        rchk(CTL_OFS, 32'h0000_0000);
        wr(CTL_OFS, 32'h0000_0060);
        rchk(CTL_OFS, 32'h0000_0000);
        eng_init_ack <= 1'b1;
        wr(CTL_OFS, 32'h0000_00E0);
        rchk(CTL_OFS, 32'h0000_00E0);
        chk(clk_sel_bus, 1'b1);
        chk(module_on, 1'b1);
        wr(CTL_OFS, 32'h0000_0020);
        rchk(CTL_OFS, 32'h0000_00A0);
        chk(clk_sel_bus, 1'b0);
        special_mode <= 1'b1;
        wr(CTL_OFS, 32'h0000_0020);
        rchk(CTL_OFS, 32'h0000_0020);
        wr(CTL_OFS, 32'h0000_00A0);
        rchk(8'hFC, 32'h0000_0000);
        chk(slv, 1'b1);
        wr(MASK_OFS, 32'h0000_0003);
        for (i = 0; i < 3; i++) begin
            wr(PRIO_OFS + 8'(4 * i), {28'h0, prio[i]});
            wr(FRAME_OFS + 8'(4 * i), {28'h0, code[i]});
        end
        eng_init_ack <= 1'b0;
        wr(INIT_OFS, 32'h0000_0000);
        wr(TXE_OFS, 32'h0000_0007);
        // loopback: transmitter feeds receiver, pin stays recessive
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(eng_rx_bit, 1'b0);
        chk(tx_pin, 1'b1);
        @(posedge pclk);
        eng_tx_bit <= 1'b1;
        dom <= 1'b1;
        eng_ack_slot <= 1'b1;
        eng_ack_bit <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(eng_rx_bit, 1'b1);
        chk(eng_ack_ok, 1'b1);
        @(posedge pclk);
        dom <= 1'b0;
        eng_ack_slot <= 1'b0;
        for (i = 0; i < 3; i++) begin
            eng_remote <= (i == 1);
            wait_start();
            @(negedge pclk);
            chk(eng_buf_sel, e_sel[i]);
            chk(eng_len_code, code[e_sel[i]]);
            chk(eng_data_bytes, e_cnt[i]);
            @(posedge pclk);
            eng_tx_busy <= 1'b1;
            repeat (2) @(posedge pclk);
            {eng_tx_busy, eng_tx_done, eng_rx_done} <= 3'b011;
            @(posedge pclk);
            {eng_tx_done, eng_rx_done} <= 2'b00;
            repeat (3) @(posedge pclk);
        end
        rchk(IRQ_OFS, 32'h0000_0003);
        chk(irq, 1'b1);
        wr(MASK_OFS, 32'h0000_0000);
        @(negedge pclk);
        chk(irq, 1'b0);
        wr(MASK_OFS, 32'h0000_0003);
        wr(IRQ_OFS, 32'h0000_0003);
        rchk(IRQ_OFS, 32'h0000_0000);
        // listen only: no start, pin idle, counters frozen
        eng_init_ack <= 1'b1;
        wr(INIT_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0090);
        eng_init_ack <= 1'b0;
        wr(INIT_OFS, 32'h0000_0000);
        wr(TXE_OFS, 32'h0000_0001);
        {eng_tx_bit, eng_err_drive, eng_rx_err, eng_tx_err} <= 4'b0111;
        @(posedge pclk);
        {eng_rx_err, eng_tx_err} <= 2'b00;
        wait_start();
        chk(eng_start, 1'b0);
        chk(tx_pin, 1'b1);
        xfer(STAT_OFS, 1'b0, 32'h0000_0000);
        chk({16'h0, rd[23:8]}, 32'h0000_0000);
        dom <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk(eng_rx_bit, 1'b0);
        // bus-off: automatic follows the engine, user mode needs a write
        @(posedge pclk);
        {eng_busoff, eng_busoff_done, dom} <= 3'b110;
        @(posedge pclk);
        eng_busoff_done <= 1'b0;
        eng_init_ack <= 1'b1;
        @(negedge pclk);
        chk(eng_busoff_clear, 1'b1);
        wr(INIT_OFS, 32'h0000_0001);
        wr(CTL_OFS, 32'h0000_0098);
        eng_busoff_done <= 1'b1;
        @(posedge pclk);
        eng_busoff_done <= 1'b0;
        @(negedge pclk);
        chk(eng_busoff_clear, 1'b0);
        wr(INIT_OFS, 32'h0000_0006);
        @(negedge pclk);
        chk(eng_busoff_clear, 1'b1);
        // wake-up: any dominant level, then only a long enough pulse
        @(posedge pclk);
        dom <= 1'b1;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(sleep_wake, 1'b1);
        @(posedge pclk);
        {eng_busoff, dom} <= 2'b00;
        wr(INIT_OFS, 32'h0000_0003);
        wr(CTL_OFS, 32'h0000_009C);
        wr(INIT_OFS, 32'h0000_0002);
        wr(IRQ_OFS, 32'h0000_000F);
        dom <= 1'b1;
        repeat (2) @(posedge pclk);
        dom <= 1'b0;
        rchk(IRQ_OFS, 32'h0000_0000);
        dom <= 1'b1;
        repeat (6) @(posedge pclk);
        dom <= 1'b0;
        rchk(IRQ_OFS, 32'h0000_0004);
        finish_test();
    end
endmodule
`default_nettype wire
